// ---- common/csr_regs.svh ----
`ifndef CSR_REGS_SVH
`define CSR_REGS_SVH

// -------------------------------------------------------------
// command codes (low byte of each word)
// -------------------------------------------------------------
`define CSR_CMD_CONF    8'h00
`define CSR_CMD_THR_HI  8'h04
`define CSR_CMD_THR_LO  8'h06
`define CSR_CMD_RED     8'h10

// -------------------------------------------------------------
// field positions
// -------------------------------------------------------------
`define CSR_C0_OFF      0
`define CSR_C0_GINT_EN  1
`define CSR_C1_ON       7
`define CSR_C1_HALF_PD  6
`define CSR_C1_GAIN_HI  4
`define CSR_C1_GAIN_LO  3
`define CSR_C1_PERS_HI  2
`define CSR_C1_PERS_LO  1
`define CSR_C1_CAL      0

// -------------------------------------------------------------
// reset values
// -------------------------------------------------------------
`define CSR_CONF0_RST   8'h01
`define CSR_CONF1_RST   8'h00
`define CSR_THR_RST     16'h0000
`define CSR_RED_RST     16'h0000

`endif

// ---- common/csr_pkg.sv ----
`default_nettype none
package csr_pkg;

    // serial slave states, one-hot
    typedef enum logic [6:0] {
        CSR_IDLE  = 7'h01,
        CSR_ADDR  = 7'h02,
        CSR_ACK_A = 7'h04,
        CSR_WR    = 7'h08,
        CSR_ACK_W = 7'h10,
        CSR_RD    = 7'h20,
        CSR_ACK_R = 7'h40
    } csr_fsm_t;

    // one finished measurement from the converter logic
    typedef struct packed {
        logic        done;
        logic [15:0] red;
        logic [15:0] green;
    } csr_meas_t;

    // settings driven into the analog front end
    typedef struct packed {
        logic       sensor_on;
        logic       half_diode;
        logic [1:0] gain;
        logic       calib_en;
    } csr_ctrl_t;

    // whole state of the block
    typedef struct packed {
        csr_fsm_t    fsm;
        logic [2:0]  scl_sy;
        logic [2:0]  sda_sy;
        logic [3:0]  cnt;
        logic [7:0]  sh;
        logic        rw;
        logic        first;
        logic        nack;
        logic [7:0]  ptr;
        logic [7:0]  stage;
        logic        sda_oe;
        logic        sda_o;
        logic [7:0]  conf0;
        logic [7:0]  conf1;
        logic [15:0] thr_hi;
        logic [15:0] thr_lo;
        logic [15:0] red;
        logic [3:0]  pers_cnt;
        logic        green_int;
        logic        sensor_on;
    } csr_state_t;

endpackage
`default_nettype wire

// ---- hdl/csr_config_threshold.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "csr_regs.svh"

module csr_config_threshold
    import csr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h10
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // serial host pins, data is open drain
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // measurement results
    input  wire csr_meas_t  meas,
    input  wire logic       green_int_clear,
    // front end control and event
    output csr_ctrl_t       ctrl,
    output logic            green_int
);

    csr_state_t st;
    csr_state_t next_st;

    // -------------------------------------------------------------
    // bus condition detection
    // -------------------------------------------------------------
    // bit 0 is the first sync stage, bit 1 the second, bit 2 the previous
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic byte_full;
    logic out_win;
    logic [3:0] pers_target;
    logic [7:0] rd_byte;
    logic [7:0] rd_ptr;
    logic [15:0] rd_word;

    assign scl_rise  = st.scl_sy[1] & ~st.scl_sy[2];
    assign scl_fall  = ~st.scl_sy[1] & st.scl_sy[2];
    assign bus_start = st.scl_sy[1] & st.scl_sy[2] & ~st.sda_sy[1] & st.sda_sy[2];
    assign bus_stop  = st.scl_sy[1] & st.scl_sy[2] & st.sda_sy[1] & ~st.sda_sy[2];
    assign byte_full = (st.cnt == 4'h8);

    assign out_win = (meas.green > st.thr_hi) | (meas.green < st.thr_lo);
    assign pers_target = 4'(4'h1 << st.conf1[`CSR_C1_PERS_HI:`CSR_C1_PERS_LO]);

    // -------------------------------------------------------------
    // read data mux
    // -------------------------------------------------------------
    // unmapped command codes read as zero
    always_comb begin
        // a read acknowledge fetches the byte after the one just sent
        rd_ptr = (st.fsm == CSR_ACK_R) ? 8'(st.ptr + 8'h01) : st.ptr;
        case ({rd_ptr[7:1], 1'b0})
            `CSR_CMD_CONF:   rd_word = {st.conf1, st.conf0};
            `CSR_CMD_THR_HI: rd_word = st.thr_hi;
            `CSR_CMD_THR_LO: rd_word = st.thr_lo;
            `CSR_CMD_RED:    rd_word = st.red;
            default:         rd_word = 16'h0000;
        endcase
        rd_byte = rd_ptr[0] ? rd_word[15:8] : rd_word[7:0];
    end

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.scl_sy = {st.scl_sy[1:0], scl_in};
        next_st.sda_sy = {st.sda_sy[1:0], sda_in};
        if (scl_rise && !byte_full) begin
            next_st.cnt = 4'(st.cnt + 4'h1);
        end
        case (st.fsm)
            CSR_IDLE: begin
                next_st.sda_oe = 1'b0;
            end
            CSR_ADDR: begin
                if (scl_rise && !byte_full) begin
                    next_st.sh = {st.sh[6:0], st.sda_sy[1]};
                end
                if (scl_fall && byte_full) begin
                    if (st.sh[7:1] == DEV_ADDR) begin
                        next_st.sda_oe = 1'b1;
                        next_st.rw     = st.sh[0];
                        next_st.fsm    = CSR_ACK_A;
                    end else begin
                        next_st.fsm = CSR_IDLE;
                    end
                end
            end
            CSR_ACK_A: begin
                if (scl_fall) begin
                    next_st.cnt = 4'h0;
                    if (st.rw) begin
                        next_st.sh     = rd_byte;
                        next_st.sda_oe = ~rd_byte[7];
                        next_st.fsm    = CSR_RD;
                    end else begin
                        next_st.sda_oe = 1'b0;
                        next_st.first  = 1'b1;
                        next_st.fsm    = CSR_WR;
                    end
                end
            end
            CSR_WR: begin
                if (scl_rise && !byte_full) begin
                    next_st.sh = {st.sh[6:0], st.sda_sy[1]};
                end
                if (scl_fall && byte_full) begin
                    next_st.sda_oe = 1'b1;
                    next_st.fsm    = CSR_ACK_W;
                    if (st.first) begin
                        next_st.first = 1'b0;
                        next_st.ptr   = st.sh;
                    end else if (!st.ptr[0]) begin
                        // low byte waits so the word lands in one step
                        next_st.stage = st.sh;
                        next_st.ptr   = 8'(st.ptr + 8'h01);
                    end else begin
                        next_st.ptr = 8'(st.ptr + 8'h01);
                        case ({st.ptr[7:1], 1'b0})
                            `CSR_CMD_CONF: begin
                                next_st.conf0 = st.stage;
                                next_st.conf1 = st.sh;
                            end
                            `CSR_CMD_THR_HI: next_st.thr_hi = {st.sh, st.stage};
                            `CSR_CMD_THR_LO: next_st.thr_lo = {st.sh, st.stage};
                            default: ;
                        endcase
                    end
                end
            end
            CSR_ACK_W: begin
                if (scl_fall) begin
                    next_st.sda_oe = 1'b0;
                    next_st.cnt    = 4'h0;
                    next_st.fsm    = CSR_WR;
                end
            end
            CSR_RD: begin
                if (scl_fall) begin
                    if (byte_full) begin
                        next_st.sda_oe = 1'b0;
                        next_st.fsm    = CSR_ACK_R;
                    end else begin
                        next_st.sh     = {st.sh[6:0], 1'b0};
                        next_st.sda_oe = ~st.sh[6];
                    end
                end
            end
            CSR_ACK_R: begin
                if (scl_rise) begin
                    next_st.nack = st.sda_sy[1];
                end
                if (scl_fall) begin
                    // host acknowledge asks for the next byte
                    if (st.nack) begin
                        next_st.fsm = CSR_IDLE;
                    end else begin
                        next_st.ptr    = 8'(st.ptr + 8'h01);
                        next_st.cnt    = 4'h0;
                        next_st.sh     = rd_byte;
                        next_st.sda_oe = ~rd_byte[7];
                        next_st.fsm    = CSR_RD;
                    end
                end
            end
            default: begin
                next_st.fsm = CSR_IDLE;
            end
        endcase
        // start and stop override any state; pointer survives a restart
        if (bus_start) begin
            next_st.fsm    = CSR_ADDR;
            next_st.cnt    = 4'h0;
            next_st.sda_oe = 1'b0;
        end else if (bus_stop) begin
            next_st.fsm    = CSR_IDLE;
            next_st.sda_oe = 1'b0;
        end

        // result loads from the converter only
        if (meas.done) begin
            next_st.red = meas.red;
        end
        // consecutive out-of-window count, set beats clear
        if (green_int_clear) begin
            next_st.green_int = 1'b0;
        end
        if (meas.done) begin
            if (!out_win) begin
                next_st.pers_cnt = 4'h0;
            end else if (4'(st.pers_cnt + 4'h1) >= pers_target) begin
                next_st.pers_cnt = 4'h0;
                if (st.conf0[`CSR_C0_GINT_EN]) begin
                    next_st.green_int = 1'b1;
                end
            end else begin
                next_st.pers_cnt = 4'(st.pers_cnt + 4'h1);
            end
        end
        // on only when the on bit is set and the off bit is clear
        next_st.sensor_on = next_st.conf1[`CSR_C1_ON] & ~next_st.conf0[`CSR_C0_OFF];
    end

    // -------------------------------------------------------------
    // state register
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st        <= '0;
            st.fsm    <= CSR_IDLE;
            st.scl_sy <= 3'h7;
            st.sda_sy <= 3'h7;
            st.conf0  <= `CSR_CONF0_RST;
            st.conf1  <= `CSR_CONF1_RST;
            st.thr_hi <= `CSR_THR_RST;
            st.thr_lo <= `CSR_THR_RST;
            st.red    <= `CSR_RED_RST;
        end else begin
            st <= next_st;
        end
    end

    // outputs are state flops
    assign sda_out          = st.sda_o;
    assign sda_oe           = st.sda_oe;
    assign green_int        = st.green_int;
    assign ctrl.sensor_on   = st.sensor_on;
    assign ctrl.half_diode  = st.conf1[`CSR_C1_HALF_PD];
    assign ctrl.gain        = st.conf1[`CSR_C1_GAIN_HI:`CSR_C1_GAIN_LO];
    assign ctrl.calib_en    = st.conf1[`CSR_C1_CAL];

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    conf_reset_a: assert property (@(posedge sys_clk)
        !rst_n |=> (st.conf0 == `CSR_CONF0_RST && st.conf1 == `CSR_CONF1_RST))
        else $error("configuration not at reset value");

    power_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ctrl.sensor_on == (st.conf1[`CSR_C1_ON] & ~st.conf0[`CSR_C0_OFF]))
        else $error("sensor on does not follow power bits");

    pair_commit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(st.thr_hi) |-> ($past(st.ptr[0]) && $past(st.fsm) == CSR_WR))
        else $error("threshold changed outside word commit");

    lo_commit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(st.thr_lo) |-> ($past(st.ptr) == 8'h07 && $past(st.fsm) == CSR_WR))
        else $error("low threshold changed outside word commit");

    conf_pair_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(st.conf1) |-> ($past(st.ptr) == 8'h01 && $past(st.fsm) == CSR_WR))
        else $error("configuration changed outside pair commit");

    int_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (green_int && !green_int_clear) |=> green_int)
        else $error("green event dropped without clear");

    int_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (green_int_clear && !meas.done) |=> !green_int)
        else $error("green event survived clear");

    red_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(st.red) |-> $past(meas.done))
        else $error("red result changed without measurement");

    gint_cause_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(green_int) |-> ($past(meas.done) && $past(st.conf0[`CSR_C0_GINT_EN])))
        else $error("green event without enabled measurement");

    persist_one_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (meas.done && out_win && st.conf1[2:1] == 2'h0 && st.conf0[`CSR_C0_GINT_EN])
        |=> green_int)
        else $error("single crossing did not raise event");

    persist_eight_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ($rose(green_int) && $past(st.conf1[2:1]) == 2'h3) |-> $past(st.pers_cnt) == 4'h7)
        else $error("eight crossing count wrong");

    addr_nack_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st.fsm == CSR_ADDR && scl_fall && byte_full && st.sh[7:1] != DEV_ADDR && !bus_start)
        |=> (!sda_oe && st.fsm == CSR_IDLE))
        else $error("foreign address acknowledged");

endmodule // csr_config_threshold
`default_nettype wire

// ---- testbench/csr_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------
// serial host: open drain data, pull-up on the line
// --------------------------------------------------
module csr_host_model (
    // clock that paces the host
    input  wire logic sys_clk,
    // device pull-down request
    input  wire logic dev_pull,
    // bus lines
    output logic      scl_line,
    output logic      sda_line
);
    logic host_rel;

    // wired-and: a released line floats high through the pull-up
    assign sda_line = host_rel & ~dev_pull;

    // bus idle at time zero
    initial begin
        scl_line = 1'b1;
        host_rel = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // data moves one cycle after the clock fall, away from the edge
    task automatic bit_io(input logic b, output logic s);
        hold(1);
        host_rel = b;
        hold(4);
        scl_line = 1'b1;
        hold(3);
        s = sda_line;
        hold(2);
        scl_line = 1'b0;
    endtask

    // start, also used as repeated start
    task automatic start();
        hold(1);
        host_rel = 1'b1;
        hold(4);
        scl_line = 1'b1;
        hold(4);
        host_rel = 1'b0;
        hold(4);
        scl_line = 1'b0;
    endtask

    task automatic stop();
        hold(1);
        host_rel = 1'b0;
        hold(4);
        scl_line = 1'b1;
        hold(4);
        host_rel = 1'b1;
        hold(4);
    endtask

    // msb first, ack is the line pulled low on the ninth bit
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(nack, s);
    endtask
endmodule // csr_host_model

`default_nettype wire

// ---- testbench/tb_csr_config_threshold.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_csr_config_threshold;
    import csr_pkg::*;
    localparam logic [6:0] DEV = 7'h10;

    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    wire logic   scl;
    wire logic   sda;
    logic        sda_out;
    logic        sda_oe;
    csr_meas_t   meas    = '0;
    logic        gclr    = 1'b0;
    csr_ctrl_t   ctrl;
    logic        green_int;
    int          err_count = 0;
    int          checked   = 0;
    int          seed      = 43702;
    int          cnt_m;
    int          need;
    logic        exp_int;
    logic [15:0] rd;
    logic [15:0] hi;
    logic [15:0] lo;
    logic [7:0]  c1;
    logic        nak;
    logic [15:0] m_hi    = 16'h0000;
    logic [15:0] m_lo    = 16'h0000;

    always #10 sys_clk = ~sys_clk;

    csr_config_threshold #(.DEV_ADDR(DEV)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .meas(meas),
        .green_int_clear(gclr), .ctrl(ctrl), .green_int(green_int));

    csr_host_model host (
        .sys_clk(sys_clk), .dev_pull(sda_oe), .scl_line(scl), .sda_line(sda));

    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wb(input logic [7:0] b);
        logic a;
        host.wr_byte(b, a);
        chk("ack", 16'h0001, {15'h0000, a});
    endtask

    // code and both data bytes go in one transfer so the word commits whole
    task automatic wr_word(input logic [7:0] cmd, input logic [15:0] d);
        host.start();
        wb({DEV, 1'b0});
        wb(cmd);
        wb(d[7:0]);
        wb(d[15:8]);
        host.stop();
        // reference copy of the threshold words
        if (cmd == 8'h04) m_hi = d;
        if (cmd == 8'h06) m_lo = d;
    endtask

    task automatic rd_word(input logic [7:0] cmd, output logic [15:0] d);
        host.start();
        wb({DEV, 1'b0});
        wb(cmd);
        host.start();
        wb({DEV, 1'b1});
        host.rd_byte(1'b0, d[7:0]);
        host.rd_byte(1'b1, d[15:8]);
        host.stop();
    endtask

    // one-cycle result pulse with optional clear, flag settled two cycles on
    task automatic feed(input logic [15:0] g, input logic [15:0] r, input logic clr);
        meas = {1'b1, r, g};
        gclr = clr;
        @(negedge sys_clk);
        meas.done = 1'b0;
        gclr      = 1'b0;
        repeat (2) @(negedge sys_clk);
        // a clear loses to a set in the same cycle
        if (clr) exp_int = 1'b0;
        if (g > m_hi || g < m_lo) cnt_m++;
        else cnt_m = 0;
        exp_int = exp_int | (cnt_m == need);
        if (cnt_m == need) cnt_m = 0;
        chk("green_int", {15'h0000, exp_int}, {15'h0000, green_int});
    endtask

    // a hang is cut short here
    initial begin
        repeat (60000) @(posedge sys_clk);
        err_count++;
        close_out();
    end

    initial begin
        exp_int = 1'b0;
        cnt_m   = 0;
        need    = 1000;
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (5) @(negedge sys_clk);
        rd_word(8'h00, rd);
        chk("conf_word", 16'h0001, rd);
        chk("ctrl", 16'h0000, {11'h000, ctrl});
        // a foreign address is left unanswered
        host.start();
        host.wr_byte({DEV ^ 7'h01, 1'b0}, nak);
        chk("ack", 16'h0000, {15'h0000, nak});
        host.stop();
        $display("test reset done");
        // every gain code, with bit 5 kept clear and calibration on
        for (int g = 0; g < 4; g++) begin
            c1 = {1'b1, 1'($random(seed)), 1'b0, 2'(g), 2'($random(seed)), 1'b1};
            wr_word(8'h00, {c1, 8'h02});
            rd_word(8'h00, rd);
            chk("conf_word", {c1, 8'h02}, rd);
            chk("ctrl", {11'h000, c1[7:6], c1[4:3], c1[0]}, {11'h000, ctrl});
        end
        wr_word(8'h00, {c1, 8'h03});
        chk("ctrl", {11'h000, 1'b0, c1[6], c1[4:3], c1[0]}, {11'h000, ctrl});
        $display("test config done");
        // read-only result ignores a write
        hi = 16'($random(seed));
        feed(16'h0000, hi, 1'b0);
        rd_word(8'h10, rd);
        chk("red", hi, rd);
        wr_word(8'h10, ~hi);
        rd_word(8'h10, rd);
        chk("red", hi, rd);
        $display("test red done");
        for (int i = 0; i < 3; i++) begin
            hi = (i == 0) ? 16'hFFFF : 16'($random(seed));
            lo = (i == 0) ? 16'h0000 : 16'($random(seed));
            wr_word(8'h04, hi);
            wr_word(8'h06, lo);
            rd_word(8'h04, rd);
            chk("thr_hi", hi, rd);
            rd_word(8'h06, rd);
            chk("thr_lo", lo, rd);
        end
        $display("test thresholds done");
        wr_word(8'h04, 16'h8000);
        wr_word(8'h06, 16'h1000);
        // window edges are in window and restart the count
        for (int p = 0; p < 4; p++) begin
            wr_word(8'h00, {1'b1, 1'b0, 1'b0, 2'b00, 2'(p), 1'b1, 8'h02});
            need = 1 << p;
            feed(16'h8000, 16'h0000, 1'b1);
            feed(16'h8001, 16'h0000, 1'b0);
            feed(16'h1000, 16'h0000, 1'b0);
            for (int k = 0; k < need; k++) begin
                feed(($random(seed) & 1) ? 16'h8001 : 16'h0FFF, 16'h0000, 1'b0);
            end
        end
        // a result and a clear in the same cycle: the set wins
        wr_word(8'h00, {8'h81, 8'h02});
        need = 1;
        feed(16'h0FFF, 16'h0000, 1'b1);
        $display("test persistence done");
        close_out();
    end
endmodule // tb_csr_config_threshold

`default_nettype wire
